// File: logic/dsp_mac_slice.sv
// multiply-accumulate slice: pre-adder, multiplier, simd alu, pattern detect
//
// What this block does
// - signed 25 by 18 full product
// - 48-bit accumulator adds result each enabled cycle
// - run-time multiplier bypass feeds 48-bit operands
// - simd 48, 2x24, 4x12 lanes, no carry
// - logic unit with ten bitwise functions
// - optional pre-adder ahead of multiplier
// - 48-bit masked pattern detector for rounding
// - detector plus logic unit gives 96-input functions
// - optional pipeline stage and cascade buses
// - accumulator counts up or down per enabled edge
`timescale 1ns/10ps
module dsp_mac_slice (
    input  wire logic                   clock_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   ce_in,
    input  wire logic                   srst_in,
    input  wire logic                   mreg_use_in,
    input  wire logic [24:0]            a_in,
    input  wire logic [24:0]            d_in,
    input  wire logic [17:0]            b_in,
    input  wire logic [47:0]            c_in,
    input  wire logic [47:0]            ab_in,
    input  wire logic [47:0]            pcin_in,
    input  wire logic [47:0]            pattern_in,
    input  wire logic [47:0]            mask_in,
    input  wire logic                   pre_en_in,
    input  wire logic                   pre_sub_in,
    input  wire logic                   bypass_in,
    input  wire logic                   sub_in,
    input  wire logic                   count_in,
    input  wire logic                   logic_en_in,
    input  wire dsp_mac_pkg::simd_t     simd_in,
    input  wire dsp_mac_pkg::zsel_t     zsel_in,
    input  wire dsp_mac_pkg::logic_fn_t logic_fn_in,
    output logic      [47:0]            p_out,
    output logic      [47:0]            pcout_out,
    output logic      [17:0]            bcout_out,
    output logic      [3:0]             carry_out,
    output logic                        pat_match_out,
    output logic                        pat_match_n_out
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // lane-split add or subtract; carry is cut at each active lane edge
    function automatic logic [51:0] simd_addsub(input logic [47:0] z, input logic [47:0] x,
                                                input logic sub, input dsp_mac_pkg::simd_t md);
        logic [12:0] seg;
        logic [11:0] xs;
        logic        c;
        logic        edge_seg;
        logic [47:0] s;
        logic [3:0]  co;
        int          lo;
        c  = 1'b0;
        s  = dsp_mac_pkg::P_RST;
        co = 4'h0;
        for (int i = 0; i < dsp_mac_pkg::N_SEG; i++) begin
            edge_seg = (i == 0) || (md == dsp_mac_pkg::SIMD_FOUR12) ||
                       ((md == dsp_mac_pkg::SIMD_TWO24) && (i == dsp_mac_pkg::N_SEG / 2));
            if (edge_seg) begin
                c = sub;
            end
            lo  = i * dsp_mac_pkg::LANE_W;
            xs  = sub ? ~x[lo +: dsp_mac_pkg::LANE_W] : x[lo +: dsp_mac_pkg::LANE_W];
            seg = {1'b0, z[lo +: dsp_mac_pkg::LANE_W]} + {1'b0, xs} + {12'h0, c};
            s[lo +: dsp_mac_pkg::LANE_W] = seg[11:0];
            c     = seg[12];
            co[i] = seg[12];
        end
        return {co, s};
    endfunction

    // masked compare, masked bits always match
    function automatic logic pat_hit(input logic [47:0] v, input logic [47:0] pat,
                                     input logic [47:0] msk);
        return &(~(v ^ pat) | msk);
    endfunction

    // ------------------------------------------------------------------
    // input stage
    // ------------------------------------------------------------------
    logic [24:0]        a_r, d_r;
    logic [17:0]        b_r;
    logic [47:0]        c_r, ab_r;
    dsp_mac_pkg::ctrl_t s1_ctrl_r, ctrl_in;

    // controls travel with the operands they were presented with
    assign ctrl_in = '{pre_en: pre_en_in, pre_sub: pre_sub_in, bypass: bypass_in,
                       sub: sub_in, count: count_in, logic_en: logic_en_in,
                       simd: simd_in, zsel: zsel_in, fn: logic_fn_in};

    // operand and control capture
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            a_r <= '0;
            d_r <= '0;
            b_r <= '0;
            c_r <= dsp_mac_pkg::P_RST;
            ab_r <= dsp_mac_pkg::P_RST;
            s1_ctrl_r <= dsp_mac_pkg::CTRL_RST;
        end else if (srst_in) begin
            a_r <= '0;
            d_r <= '0;
            b_r <= '0;
            c_r <= dsp_mac_pkg::P_RST;
            ab_r <= dsp_mac_pkg::P_RST;
            s1_ctrl_r <= dsp_mac_pkg::CTRL_RST;
        end else if (ce_in) begin
            a_r <= a_in;
            d_r <= d_in;
            b_r <= b_in;
            c_r <= c_in;
            ab_r <= ab_in;
            s1_ctrl_r <= ctrl_in;
        end
    end

    assign bcout_out = b_r;

    // ------------------------------------------------------------------
    // pre-adder and multiplier
    // ------------------------------------------------------------------
    logic [24:0]        pre_sum;
    logic signed [42:0] prod_c;
    logic [42:0]        m_prod_r;
    logic [47:0]        m_ab_r, m_c_r;
    dsp_mac_pkg::ctrl_t m_ctrl_r;

    // pre-adder folds a symmetric tap pair into one product
    assign pre_sum = s1_ctrl_r.pre_en ? (s1_ctrl_r.pre_sub ? d_r - a_r : d_r + a_r)
                                      : a_r;
    assign prod_c  = $signed(pre_sum) * $signed(b_r);

    // optional product pipeline stage
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            m_prod_r <= '0;
            m_ab_r <= dsp_mac_pkg::P_RST;
            m_c_r <= dsp_mac_pkg::P_RST;
            m_ctrl_r <= dsp_mac_pkg::CTRL_RST;
        end else if (srst_in) begin
            m_prod_r <= '0;
            m_ab_r <= dsp_mac_pkg::P_RST;
            m_c_r <= dsp_mac_pkg::P_RST;
            m_ctrl_r <= dsp_mac_pkg::CTRL_RST;
        end else if (ce_in) begin
            m_prod_r <= prod_c;
            m_ab_r <= ab_r;
            m_c_r <= c_r;
            m_ctrl_r <= s1_ctrl_r;
        end
    end

    // ------------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------------
    logic [42:0]        ex_prod;
    logic [47:0]        ex_ab, ex_c, ex_x, ex_z;
    dsp_mac_pkg::ctrl_t ex_ctrl;

    // stage used or skipped at run time
    assign ex_prod = mreg_use_in ? m_prod_r : prod_c;
    assign ex_ab   = mreg_use_in ? m_ab_r : ab_r;
    assign ex_c    = mreg_use_in ? m_c_r : c_r;
    assign ex_ctrl = mreg_use_in ? m_ctrl_r : s1_ctrl_r;

    // x operand: count step, bypass word or sign-extended product
    always_comb begin
        if (ex_ctrl.count) begin
            ex_x = dsp_mac_pkg::CNT_ONE;
        end else if (ex_ctrl.bypass) begin
            ex_x = ex_ab;
        end else begin
            ex_x = {{dsp_mac_pkg::EXT_W{ex_prod[42]}}, ex_prod};
        end
    end

    // z operand: zero, own accumulator, cascade in, or c word
    always_comb begin
        case (ex_ctrl.zsel)
            dsp_mac_pkg::ZS_ZERO: ex_z = dsp_mac_pkg::P_RST;
            dsp_mac_pkg::ZS_ACC:  ex_z = p_out;
            dsp_mac_pkg::ZS_CASC: ex_z = pcin_in;
            dsp_mac_pkg::ZS_CREG: ex_z = ex_c;
            default:              ex_z = dsp_mac_pkg::P_RST;
        endcase
    end

    // ------------------------------------------------------------------
    // alu and logic unit
    // ------------------------------------------------------------------
    logic [47:0] lu_res, alu_sum, res;
    logic [3:0]  alu_carry;

    dsp_logic_unit u_logic (
        .x_in    (ex_x),
        .z_in    (ex_z),
        .fn_in   (ex_ctrl.fn),
        .res_out (lu_res)
    );

    assign {alu_carry, alu_sum} = simd_addsub(ex_z, ex_x, ex_ctrl.sub, ex_ctrl.simd);
    assign res = ex_ctrl.logic_en ? lu_res : alu_sum;

    // ------------------------------------------------------------------
    // result register and pattern detector
    // ------------------------------------------------------------------
    // accumulator, lane carries and match flags
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            p_out <= dsp_mac_pkg::P_RST;
            carry_out <= 4'h0;
            pat_match_out <= 1'b0;
            pat_match_n_out <= 1'b0;
        end else if (srst_in) begin
            p_out <= dsp_mac_pkg::P_RST;
            carry_out <= 4'h0;
            pat_match_out <= 1'b0;
            pat_match_n_out <= 1'b0;
        end else if (ce_in) begin
            p_out <= res;
            carry_out <= ex_ctrl.logic_en ? 4'h0 : alu_carry;
            pat_match_out <= pat_hit(res, pattern_in, mask_in);
            pat_match_n_out <= pat_hit(res, ~pattern_in, mask_in);
        end
    end

    assign pcout_out = p_out;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_mul_cap;
        ce_in && !srst_in && !pre_en_in ##1 ce_in && !srst_in;
    endsequence
    sequence s_pre_cap;
        ce_in && !srst_in && pre_en_in && !pre_sub_in ##1 ce_in && !srst_in;
    endsequence

    property p_mult_full;
        s_mul_cap |=> $signed(m_prod_r) == $signed($past(a_in, 2)) * $signed($past(b_in, 2));
    endproperty
    a_mult_full: assert property (p_mult_full) else $error("product wrong");

    property p_pre_add;
        s_pre_cap |=> $signed(m_prod_r) ==
            $signed(25'($past(d_in, 2) + $past(a_in, 2))) * $signed($past(b_in, 2));
    endproperty
    a_pre_add: assert property (p_pre_add) else $error("pre-add product wrong");

    property p_count_up;
        ce_in && !srst_in && ex_ctrl.count && !ex_ctrl.sub && !ex_ctrl.logic_en &&
        ex_ctrl.zsel == dsp_mac_pkg::ZS_ACC && ex_ctrl.simd == dsp_mac_pkg::SIMD_ONE48
        |=> p_out == 48'($past(p_out) + 48'h1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter step wrong");

    property p_simd12;
        ce_in && !srst_in && !ex_ctrl.logic_en && !ex_ctrl.sub &&
        ex_ctrl.simd == dsp_mac_pkg::SIMD_FOUR12
        |=> p_out[23:12] == 12'($past(ex_z[23:12]) + $past(ex_x[23:12]));
    endproperty
    a_simd12: assert property (p_simd12) else $error("lane carry leaked");

    property p_logic_and;
        ce_in && !srst_in && ex_ctrl.logic_en && ex_ctrl.fn == dsp_mac_pkg::LF_AND
        |=> p_out == $past(ex_x & ex_z);
    endproperty
    a_logic_and: assert property (p_logic_and) else $error("logic and wrong");

    property p_bypass;
        ce_in && !srst_in && ex_ctrl.bypass && !ex_ctrl.count && !ex_ctrl.logic_en &&
        !ex_ctrl.sub && ex_ctrl.zsel == dsp_mac_pkg::ZS_ZERO
        |=> p_out == $past(ex_ab);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");

    property p_srst;
        srst_in |=> p_out == dsp_mac_pkg::P_RST && m_prod_r == '0 && bcout_out == '0;
    endproperty
    a_srst: assert property (p_srst) else $error("sync reset missed");

    property p_hold;
        !ce_in && !srst_in |=> $stable(p_out) && $stable(bcout_out) && $stable(m_prod_r);
    endproperty
    a_hold: assert property (p_hold) else $error("moved without enable");

    property p_pattern;
        ce_in && !srst_in
        |=> pat_match_out == &(~(p_out ^ $past(pattern_in)) | $past(mask_in));
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern flag wrong");

    property p_wide_logic;
        ce_in && !srst_in && ex_ctrl.logic_en && ex_ctrl.fn == dsp_mac_pkg::LF_XOR
        |=> pat_match_out == &(~($past(ex_x ^ ex_z) ^ $past(pattern_in)) | $past(mask_in));
    endproperty
    a_wide_logic: assert property (p_wide_logic) else $error("wide logic wrong");

    property p_cascade;
        ce_in && !srst_in && !ex_ctrl.logic_en && !ex_ctrl.sub &&
        ex_ctrl.zsel == dsp_mac_pkg::ZS_CASC && ex_ctrl.simd == dsp_mac_pkg::SIMD_ONE48
        |=> p_out == 48'($past(pcin_in) + $past(ex_x)) && pcout_out == p_out;
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade sum wrong");

endmodule

// File: logic/dsp_mac_pkg.sv
// shared widths, modes and reset values of the multiply-accumulate slice
package dsp_mac_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int A_W    = 25;
    localparam int B_W    = 18;
    localparam int M_W    = A_W + B_W;
    localparam int P_W    = 48;
    localparam int EXT_W  = P_W - M_W;
    localparam int LANE_W = 12;
    localparam int N_SEG  = P_W / LANE_W;

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [P_W-1:0] P_RST   = 48'h0;
    localparam logic [P_W-1:0] CNT_ONE = 48'h1;

    // ------------------------------------------------------------------
    // modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12} simd_t;
    typedef enum logic [1:0] {ZS_ZERO, ZS_ACC, ZS_CASC, ZS_CREG} zsel_t;
    typedef enum logic [3:0] {
        LF_AND, LF_OR, LF_XOR, LF_XNOR, LF_NAND, LF_NOR,
        LF_X_ANDN_Z, LF_X_ORN_Z, LF_NX_AND_Z, LF_NX_OR_Z
    } logic_fn_t;

    typedef struct packed {
        logic      pre_en;
        logic      pre_sub;
        logic      bypass;
        logic      sub;
        logic      count;
        logic      logic_en;
        simd_t     simd;
        zsel_t     zsel;
        logic_fn_t fn;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '0;

endpackage

// File: logic/dsp_logic_unit.sv
// bitwise logic unit selecting one of ten functions of two operands
`timescale 1ns/10ps
module dsp_logic_unit (
    input  wire logic [47:0]           x_in,
    input  wire logic [47:0]           z_in,
    input  wire dsp_mac_pkg::logic_fn_t fn_in,
    output logic      [47:0]           res_out
);

    // function select, unused codes give zero
    always_comb begin
        case (fn_in)
            dsp_mac_pkg::LF_AND:      res_out = x_in & z_in;
            dsp_mac_pkg::LF_OR:       res_out = x_in | z_in;
            dsp_mac_pkg::LF_XOR:      res_out = x_in ^ z_in;
            dsp_mac_pkg::LF_XNOR:     res_out = ~(x_in ^ z_in);
            dsp_mac_pkg::LF_NAND:     res_out = ~(x_in & z_in);
            dsp_mac_pkg::LF_NOR:      res_out = ~(x_in | z_in);
            dsp_mac_pkg::LF_X_ANDN_Z: res_out = x_in & ~z_in;
            dsp_mac_pkg::LF_X_ORN_Z:  res_out = x_in | ~z_in;
            dsp_mac_pkg::LF_NX_AND_Z: res_out = ~x_in & z_in;
            dsp_mac_pkg::LF_NX_OR_Z:  res_out = ~x_in | z_in;
            default:                  res_out = dsp_mac_pkg::P_RST;
        endcase
    end

endmodule

// File: verification/fabric_user_model.sv
// surrounding fabric model: cascade source and detector pattern presentation
`timescale 1ns/10ps
module fabric_user_model (
    input  wire logic        clock_in,
    input  wire logic [47:0] casc_val_in,
    input  wire logic [47:0] pat_val_in,
    input  wire logic [47:0] msk_val_in,
    output logic      [47:0] pcin_out,
    output logic      [47:0] pattern_out,
    output logic      [47:0] mask_out
);
    // ------------------------------------------------------------------
    // presentation
    // ------------------------------------------------------------------
    // start from known values so nothing unknown reaches the slice
    initial begin
        pcin_out    = 48'h0;
        pattern_out = 48'h0;
        mask_out    = 48'h0;
    end

    // fabric flops launch off the falling edge, one cycle after the request
    always @(negedge clock_in) begin
        pcin_out    <= casc_val_in;
        pattern_out <= pat_val_in;
        mask_out    <= msk_val_in;
    end
endmodule

// File: verification/dsp_mac_slice_tb.sv
// self-checking bench for the multiply-accumulate slice
`timescale 1ns/10ps
module dsp_mac_slice_tb;
    typedef struct {
        logic [24:0] a, d; logic [17:0] b; logic [47:0] c, ab, pc;
        logic [3:0]  fl; logic [1:0] md, zs; logic le; logic [3:0] fn; logic [47:0] exp;
    } row_t;

    logic clock_in = 1'b0, reset_n_in = 1'b0, ce_in = 1'b0, srst_in = 1'b0;
    logic mreg_use_in = 1'b0, pre_en_in = 1'b0, pre_sub_in = 1'b0, bypass_in = 1'b0;
    logic sub_in = 1'b0, count_in = 1'b0, logic_en_in = 1'b0;
    logic [24:0] a_in = 25'h0, d_in = 25'h0;
    logic [17:0] b_in = 18'h0, bcout_out;
    logic [47:0] c_in = 48'h0, ab_in = 48'h0, pcin_in, pattern_in, mask_in, p_out, pcout_out;
    logic [47:0] casc_val = 48'h0, pat_val = 48'h0, msk_val = 48'h0, p0;
    logic [3:0]  carry_out;
    logic        pat_match_out, pat_match_n_out;
    dsp_mac_pkg::simd_t     simd_in = dsp_mac_pkg::SIMD_ONE48;
    dsp_mac_pkg::zsel_t     zsel_in = dsp_mac_pkg::ZS_ZERO;
    dsp_mac_pkg::logic_fn_t fn_in   = dsp_mac_pkg::LF_AND;
    row_t rows[$];
    int   fails = 0, num_checks = 0;

    always #4 clock_in = ~clock_in;

    dsp_mac_slice dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .srst_in(srst_in), .mreg_use_in(mreg_use_in), .a_in(a_in), .d_in(d_in), .b_in(b_in),
        .c_in(c_in), .ab_in(ab_in), .pcin_in(pcin_in), .pattern_in(pattern_in),
        .mask_in(mask_in), .pre_en_in(pre_en_in), .pre_sub_in(pre_sub_in),
        .bypass_in(bypass_in), .sub_in(sub_in), .count_in(count_in),
        .logic_en_in(logic_en_in), .simd_in(simd_in), .zsel_in(zsel_in),
        .logic_fn_in(fn_in), .p_out(p_out), .pcout_out(pcout_out), .bcout_out(bcout_out),
        .carry_out(carry_out), .pat_match_out(pat_match_out),
        .pat_match_n_out(pat_match_n_out));

    fabric_user_model fab_u (.clock_in(clock_in), .casc_val_in(casc_val),
        .pat_val_in(pat_val), .msk_val_in(msk_val), .pcin_out(pcin_in),
        .pattern_out(pattern_in), .mask_out(mask_in));

    // ------------------------------------------------------------------
    // reference arithmetic
    // ------------------------------------------------------------------
    // expected result from operands and controls; fl = pre, pre_sub, bypass, sub
    function automatic logic [47:0] model(row_t r);
        logic [24:0] pa;
        logic [47:0] x, z, m, res, xs, zs;
        int          w;
        pa = r.fl[3] ? (r.fl[2] ? r.d - r.a : r.d + r.a) : r.a;
        x = r.fl[1] ? r.ab : {{23{pa[24]}}, pa} * {{30{r.b[17]}}, r.b};
        z = (r.zs == 2'h3) ? r.c : (r.zs == 2'h2) ? r.pc : 48'h0;
        if (r.le) begin
            case (r.fn)
                4'h0: res = x & z;
                4'h1: res = x | z;
                4'h2: res = x ^ z;
                4'h3: res = ~(x ^ z);
                4'h4: res = ~(x & z);
                4'h5: res = ~(x | z);
                4'h6: res = x & ~z;
                4'h7: res = x | ~z;
                4'h8: res = ~x & z;
                4'h9: res = ~x | z;
                default: res = 48'h0;
            endcase
            return res;
        end
        w = (r.md == 2'h0) ? 48 : (r.md == 2'h1) ? 24 : 12;
        m = (48'h1 << w) - 48'h1;
        res = 48'h0;
        for (int k = 0; k < 48 / w; k++) begin
            xs = x >> (k * w);
            zs = z >> (k * w);
            res |= ((r.fl[0] ? zs - xs : zs + xs) & m) << (k * w);
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // bench tasks
    // ------------------------------------------------------------------
    // queue one ordinary case with its expected result
    task automatic add(input logic [24:0] a, d, input logic [17:0] b,
                       input logic [47:0] c, ab, pc, input logic [3:0] fl,
                       input logic [1:0] md, zs, input logic le, input logic [3:0] fn);
        row_t r;
        r = '{a, d, b, c, ab, pc, fl, md, zs, le, fn, 48'h0};
        r.exp = model(r);
        rows.push_back(r);
    endtask

    // present operands and controls together, just after a falling edge
    task automatic put(row_t r);
        a_in <= r.a;
        d_in <= r.d;
        b_in <= r.b;
        c_in <= r.c;
        ab_in <= r.ab;
        casc_val <= r.pc;
        {pre_en_in, pre_sub_in, bypass_in, sub_in} <= r.fl;
        simd_in <= dsp_mac_pkg::simd_t'(r.md);
        zsel_in <= dsp_mac_pkg::zsel_t'(r.zs);
        logic_en_in <= r.le;
        fn_in <= dsp_mac_pkg::logic_fn_t'(r.fn);
        count_in <= 1'b0;
    endtask

    // compare and count
    task automatic chk(input logic [47:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        add(25'h1fffffd, 25'h0, 18'h00007, 48'h0, 48'h0, 48'h0, 4'h0, 2'h0, 2'h0, 1'b0, 4'h0);
        add(25'h1000000, 25'h0, 18'h20000, 48'h0, 48'h0, 48'h0, 4'h0, 2'h0, 2'h0, 1'b0, 4'h0);
        add(25'h5, 25'h9, 18'h3, 48'h0, 48'h0, 48'h0, 4'h8, 2'h0, 2'h0, 1'b0, 4'h0);
        add(25'h5, 25'h9, 18'h3ffff, 48'h7, 48'h0, 48'h0, 4'hc, 2'h0, 2'h3, 1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h1, 48'h123456789abc, 48'h0, 4'h2, 2'h0, 2'h3, 1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h1, 48'h123456789abc, 48'h0, 4'h3, 2'h0, 2'h3, 1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h000001000001, 48'h000001ffffff, 48'h0, 4'h2, 2'h1, 2'h3,
            1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h001001001001, 48'hffffffffffff, 48'h0, 4'h2, 2'h2, 2'h3,
            1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h0, 48'h001001001001, 48'h0, 4'h3, 2'h2, 2'h3, 1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h0, 48'h10, 48'h1000, 4'h2, 2'h0, 2'h2, 1'b0, 4'h0);
        add(25'h0, 25'h0, 18'h0, 48'h0, 48'h800000000001, 48'h0, 4'h2, 2'h2, 2'h0, 1'b0, 4'h0);
        for (int f = 0; f < 11; f++)
            add(25'h0, 25'h0, 18'h0, 48'hcccc3333cccc, 48'hf0f0f0f00f0f, 48'h0, 4'h2, 2'h0,
                2'h3, 1'b1, (f == 10) ? 4'hf : 4'(f));
        repeat (20) @(negedge clock_in);
        reset_n_in <= 1'b1;
        @(negedge clock_in);
        chk(p_out, 48'h0);
        ce_in <= 1'b1;
        foreach (rows[i]) begin
            put(rows[i]);
            msk_val <= (i % 2) ? 48'h00000000ffff : 48'h0;
            pat_val <= rows[i].exp ^ ((i % 2) ? 48'h000000005a5a : 48'h0);
            repeat (2) @(negedge clock_in);
            chk(p_out, rows[i].exp);
            chk({46'h0, pat_match_out, pat_match_n_out}, 48'h2);
            if (i == 7 || i == 8)
                chk({44'h0, carry_out}, (i == 7) ? 48'hf : 48'h0);
        end
        $display("table cases done");
        bypass_in <= 1'b1;
        ab_in <= 48'h5;
        zsel_in <= dsp_mac_pkg::ZS_ACC;
        logic_en_in <= 1'b0;
        sub_in <= 1'b0;
        simd_in <= dsp_mac_pkg::SIMD_ONE48;
        repeat (4) @(negedge clock_in);
        p0 = p_out;
        @(negedge clock_in);
        chk(p_out, p0 + 48'h5);
        count_in <= 1'b1;
        repeat (3) @(negedge clock_in);
        p0 = p_out;
        @(negedge clock_in);
        chk(p_out, p0 + 48'h1);
        sub_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        p0 = p_out;
        @(negedge clock_in);
        chk(p_out, p0 - 48'h1);
        ce_in <= 1'b0;
        b_in <= 18'h3;
        repeat (2) @(negedge clock_in);
        chk(p_out, p0 - 48'h1);
        chk({30'h0, bcout_out}, 48'h0);
        $display("accumulate and count done");
        srst_in <= 1'b1;
        @(negedge clock_in);
        chk(p_out, 48'h0);
        chk({30'h0, bcout_out}, 48'h0);
        srst_in <= 1'b0;
        ce_in <= 1'b1;
        mreg_use_in <= 1'b1;
        put('{25'h7, 25'h0, 18'h6, 48'h0, 48'h0, 48'h0, 4'h0, 2'h0, 2'h0, 1'b0, 4'h0, 48'h0});
        @(negedge clock_in);
        chk({30'h0, bcout_out}, 48'h6);
        @(negedge clock_in);
        chk(p_out, 48'h0);
        @(negedge clock_in);
        chk(p_out, 48'h2a);
        chk(pcout_out, 48'h2a);
        $display("reset and pipeline done");
        print_verdict();
    end
endmodule
